// >>> usb_power_control.sv
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
// usb power and suspend control with apb registers
module usb_power_control #(
  parameter int SETTLE = usb_power_pkg::SETTLE_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_clk_usb,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_bus_activity,
  input wire logic i_notify_pending,
  input wire logic i_activity_irq_taken,
  output logic o_module_power_on,
  output logic o_usb_outputs_enable,
  output logic o_usb_pins_own,
  output logic o_analog_enable,
  output logic o_xcvr_low_power,
  output logic o_clk_usb_gated,
  output logic o_sleep_block,
  output logic o_irq
);
  typedef struct packed {
    logic power_on;
    logic suspend;
    logic sleep_guard;
    logic act_pend;
    logic not_ready;
    logic [15:0] settle_cnt;
    logic [2:0] act_sync;
    logic [2:0] note_sync;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic outputs_en;
    logic pins_own;
    logic analog_en;
    logic xcvr_lp;
    logic sleep_block;
    logic irq;
  } state_t;
  state_t st_q;
  state_t st_d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic clk_en;
  logic gate_sync;
  logic act_lvl;
  logic note_lvl;
  logic act_rise;
  logic wr;
  logic rd;
  logic [31:0] pwrc_view;
  logic [31:0] rdata;
  logic addr_ok;
  assign rst_n = rst_sync_q[1];
  assign clk_en = st_q.power_on & ~st_q.suspend;
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  usb_clock_gate u_gate (
    .i_clk_usb(i_clk_usb),
    .i_nrst(i_nrst),
    .i_enable(clk_en),
    .o_clk_gated(o_clk_usb_gated),
    .o_enable_sync(gate_sync)
  );
  always_comb
  begin
    act_lvl = st_q.act_sync[1] & st_q.act_sync[2];
    note_lvl = st_q.note_sync[1] & st_q.note_sync[2];
    act_rise = st_q.act_sync[1] & st_q.act_sync[2] & st_q.power_on
      & ~st_q.act_pend;
    wr = i_psel & i_penable & i_pwrite & st_q.pready;
    // read data loaded with pready so it stands when sampled
    rd = i_psel & i_penable & ~i_pwrite & ~st_q.pready;
    addr_ok = (i_paddr == usb_power_pkg::PWRC_OFFSET)
      | (i_paddr == usb_power_pkg::IRQ_STATUS_OFFSET)
      | (i_paddr == usb_power_pkg::IRQ_MASK_OFFSET);
    pwrc_view = 32'h0000_0000;
    pwrc_view[usb_power_pkg::POWER_ON_BIT] = st_q.power_on;
    pwrc_view[usb_power_pkg::SUSPEND_BIT] = st_q.suspend;
    pwrc_view[usb_power_pkg::NOT_READY_BIT] = st_q.not_ready;
    pwrc_view[usb_power_pkg::SLEEP_GUARD_BIT] = st_q.sleep_guard;
    pwrc_view[usb_power_pkg::ACT_PEND_BIT] = st_q.act_pend;
    case (i_paddr)
      usb_power_pkg::PWRC_OFFSET: rdata = pwrc_view;
      usb_power_pkg::IRQ_STATUS_OFFSET: rdata = {30'h0, st_q.irq_status};
      usb_power_pkg::IRQ_MASK_OFFSET: rdata = {30'h0, st_q.irq_mask};
      default: rdata = 32'h0000_0000;
    endcase
  end
  always_comb
  begin
    st_d = st_q;
    st_d.act_sync = {st_q.act_sync[1:0], i_bus_activity};
    st_d.note_sync = {st_q.note_sync[1:0], i_notify_pending};
    // one wait state per access
    st_d.pready = i_psel & i_penable & ~st_q.pready;
    st_d.pslverr = i_psel & i_penable & ~st_q.pready & ~addr_ok;
    if (rd)
      st_d.prdata = rdata;
    if (wr && i_paddr == usb_power_pkg::PWRC_OFFSET)
    begin
      st_d.power_on = i_pwdata[usb_power_pkg::POWER_ON_BIT];
      st_d.suspend = i_pwdata[usb_power_pkg::SUSPEND_BIT];
      st_d.sleep_guard = i_pwdata[usb_power_pkg::SLEEP_GUARD_BIT];
    end
    if (wr && i_paddr == usb_power_pkg::IRQ_MASK_OFFSET)
      st_d.irq_mask = i_pwdata[1:0];
    if (wr && i_paddr == usb_power_pkg::IRQ_STATUS_OFFSET)
      st_d.irq_status = st_q.irq_status & ~i_pwdata[1:0];
    // busy while on or settling after off
    if (st_q.power_on)
    begin
      st_d.not_ready = 1'b1;
      st_d.settle_cnt = 16'(SETTLE);
    end
    else if (st_q.settle_cnt != 16'h0000)
    begin
      st_d.not_ready = 1'b1;
      st_d.settle_cnt = st_q.settle_cnt - 16'h0001;
    end
    else
      st_d.not_ready = 1'b0;
    if (act_rise)
      st_d.act_pend = 1'b1;
    else if (i_activity_irq_taken || !st_q.power_on)
      st_d.act_pend = 1'b0;
    // sticky events, set wins over clear
    if (act_rise)
      st_d.irq_status[usb_power_pkg::IRQ_ACTIVITY_BIT] = 1'b1;
    if (st_q.not_ready && !st_d.not_ready)
      st_d.irq_status[usb_power_pkg::IRQ_READY_BIT] = 1'b1;
    st_d.irq = |(st_d.irq_status & st_d.irq_mask);
    st_d.outputs_en = st_d.power_on;
    st_d.pins_own = st_d.power_on;
    st_d.analog_en = st_d.power_on;
    st_d.xcvr_lp = st_d.power_on & st_d.suspend;
    st_d.sleep_block = st_q.sleep_guard & (act_lvl | note_lvl
      | st_q.act_pend);
  end
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q.power_on <= 1'b0;
      st_q.suspend <= 1'b0;
      st_q.sleep_guard <= 1'b0;
      st_q.act_pend <= 1'b0;
      st_q.not_ready <= 1'b0;
      st_q.settle_cnt <= 16'h0000;
      st_q.act_sync <= 3'h0;
      st_q.note_sync <= 3'h0;
      st_q.irq_status <= usb_power_pkg::IRQ_RESET;
      st_q.irq_mask <= usb_power_pkg::IRQ_RESET;
      st_q.prdata <= 32'h0000_0000;
      st_q.pready <= 1'b0;
      st_q.pslverr <= 1'b0;
      st_q.outputs_en <= 1'b0;
      st_q.pins_own <= 1'b0;
      st_q.analog_en <= 1'b0;
      st_q.xcvr_lp <= 1'b0;
      st_q.sleep_block <= 1'b0;
      st_q.irq <= 1'b0;
    end
    else
    begin
      st_q.power_on <= st_d.power_on;
      st_q.suspend <= st_d.suspend;
      st_q.sleep_guard <= st_d.sleep_guard;
      st_q.act_pend <= st_d.act_pend;
      st_q.not_ready <= st_d.not_ready;
      st_q.settle_cnt <= st_d.settle_cnt;
      st_q.act_sync <= st_d.act_sync;
      st_q.note_sync <= st_d.note_sync;
      st_q.irq_status <= st_d.irq_status;
      st_q.irq_mask <= st_d.irq_mask;
      st_q.prdata <= st_d.prdata;
      st_q.pready <= st_d.pready;
      st_q.pslverr <= st_d.pslverr;
      st_q.outputs_en <= st_d.outputs_en;
      st_q.pins_own <= st_d.pins_own;
      st_q.analog_en <= st_d.analog_en;
      st_q.xcvr_lp <= st_d.xcvr_lp;
      st_q.sleep_block <= st_d.sleep_block;
      st_q.irq <= st_d.irq;
    end
  end
  assign o_prdata = st_q.prdata;
  assign o_pready = st_q.pready;
  assign o_pslverr = st_q.pslverr;
  assign o_module_power_on = st_q.power_on;
  assign o_usb_outputs_enable = st_q.outputs_en;
  assign o_usb_pins_own = st_q.pins_own;
  assign o_analog_enable = st_q.analog_en;
  assign o_xcvr_low_power = st_q.xcvr_lp;
  assign o_sleep_block = st_q.sleep_block;
  assign o_irq = st_q.irq;

  property p_off_outputs;
    @(posedge i_clk_sys) disable iff (!rst_n)
    !st_q.power_on |-> !o_usb_outputs_enable && !o_analog_enable;
  endproperty
  a_off_outputs: assert property (p_off_outputs)
    else $error("outputs active while module off");
  property p_suspend_lp;
    @(posedge i_clk_sys) disable iff (!rst_n)
    st_q.power_on && st_q.suspend |-> o_xcvr_low_power;
  endproperty
  a_suspend_lp: assert property (p_suspend_lp)
    else $error("transceiver not low power in suspend");
  property p_busy_on;
    @(posedge i_clk_sys) disable iff (!rst_n)
    st_q.power_on |=> st_q.not_ready;
  endproperty
  a_busy_on: assert property (p_busy_on)
    else $error("not ready clear while module on");
  property p_ready_after;
    @(posedge i_clk_sys) disable iff (!rst_n)
    $fell(st_q.not_ready) |-> !st_q.power_on && st_q.settle_cnt == 16'h0;
  endproperty
  a_ready_after: assert property (p_ready_after)
    else $error("ready reported too early");
  property p_guard_off;
    @(posedge i_clk_sys) disable iff (!rst_n)
    !st_q.sleep_guard |=> !o_sleep_block;
  endproperty
  a_guard_off: assert property (p_guard_off)
    else $error("sleep blocked with guard clear");
  property p_guard_pend;
    @(posedge i_clk_sys) disable iff (!rst_n)
    st_q.sleep_guard && st_q.act_pend |=> o_sleep_block;
  endproperty
  a_guard_pend: assert property (p_guard_pend)
    else $error("sleep not blocked with activity pending");
  property p_pend_set;
    @(posedge i_clk_sys) disable iff (!rst_n)
    act_rise |=> st_q.act_pend;
  endproperty
  a_pend_set: assert property (p_pend_set)
    else $error("activity pending not set");
  property p_rsvd_zero;
    @(posedge i_clk_sys) disable iff (!rst_n)
    rd && i_paddr == usb_power_pkg::PWRC_OFFSET
      |=> (o_prdata & ~32'h0000_009B) == 32'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bits read nonzero");
  property p_gate_sync;
    @(posedge i_clk_sys) disable iff (!rst_n)
    $rose(clk_en) |-> ##[1:8] gate_sync;
  endproperty
  a_gate_sync: assert property (p_gate_sync)
    else $error("clock gate enable never reached usb domain");
  c_power_up: cover property (@(posedge i_clk_sys) $rose(st_q.power_on));
  c_ready: cover property (@(posedge i_clk_sys) $fell(st_q.not_ready));
  c_suspend: cover property (@(posedge i_clk_sys) $rose(o_xcvr_low_power));
  c_block: cover property (@(posedge i_clk_sys) $rose(o_sleep_block));
endmodule

// >>> usb_power_pkg.sv
// constants for the usb power control block
// How it works
// - enable bit powers the module; cleared holds outputs idle, pins released.
// - suspend bit gates the 48 MHz clock and, with the enable bit set, puts transceiver low power.
// - not-ready reads 1 while active or still settling, 0 when ready.
// - guard bit blocks sleep while bus activity or notification pending.
// - activity-pending bit set when activity seen while on, held until the interrupt is taken or power off.
// - unimplemented bits 31-8, 6-5 and 2 read as zero.
package usb_power_pkg;
  localparam logic [11:0] PWRC_OFFSET = 12'h000;
  localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h004;
  localparam logic [11:0] IRQ_MASK_OFFSET = 12'h008;
  localparam int POWER_ON_BIT = 0;
  localparam int SUSPEND_BIT = 1;
  localparam int NOT_READY_BIT = 3;
  localparam int SLEEP_GUARD_BIT = 4;
  localparam int ACT_PEND_BIT = 7;
  localparam logic [31:0] PWRC_RESET = 32'h0000_0000;
  localparam logic [31:0] PWRC_WR_MASK = 32'h0000_0013;
  localparam int IRQ_ACTIVITY_BIT = 0;
  localparam int IRQ_READY_BIT = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam int SETTLE_NS = 1000;
  localparam int CLK_NS = 25;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
endpackage

// >>> usb_clock_gate.sv
`timescale 1ns/1ps
// glitch free clock gate with synchronised enable
module usb_clock_gate (
  input wire logic i_clk_usb,
  input wire logic i_nrst,
  input wire logic i_enable,
  output logic o_clk_gated,
  output logic o_enable_sync
);
  typedef struct packed {
    logic s1;
    logic s2;
  } gate_state_t;
  gate_state_t st_q;
  gate_state_t st_d;
  logic latch_en;
  // two stage sync into usb domain
  always_comb
  begin
    st_d = st_q;
    st_d.s1 = i_enable;
    st_d.s2 = st_q.s1;
  end
  always_ff @(posedge i_clk_usb or negedge i_nrst)
  begin
    if (!i_nrst)
      st_q <= '0;
    else
      st_q <= st_d;
  end
  // latch while clock low avoids runts
  always_latch
  begin
    if (!i_clk_usb)
      latch_en = st_q.s2;
  end
  assign o_clk_gated = i_clk_usb & latch_en;
  assign o_enable_sync = st_q.s2;
endmodule

// >>> usb_bus_model.sv
// far side stand-in: free running usb clock and bus levels
`timescale 1ns/1ps
module usb_bus_model (
  input wire logic i_act_req,
  input wire logic i_notify_req,
  output logic o_clk_usb,
  output logic o_activity,
  output logic o_notify
);
  initial
  begin
    o_clk_usb = 1'b0;
    forever #10.417 o_clk_usb = ~o_clk_usb;
  end
  // levels change only on the usb side clock
  always @(posedge o_clk_usb)
  begin
    o_activity <= i_act_req;
    o_notify <= i_notify_req;
  end
endmodule

// >>> usb_power_control_test.sv
// self-checking bench for the usb power control block
`timescale 1ns/1ps
module usb_power_control_test;
  localparam int SET = 20;
  logic clk, nrst, psel, pen, pw, perr, prdy, err, taken;
  logic [11:0] pa;
  logic [31:0] pwd, prd, rd;
  logic act_req, ntf_req, clk_usb, act, ntf;
  logic pon, outs, pins, ana, lowp, gclk, sblk, irq;
  int errors, samples_checked, gcnt, m_ctl, m_st, m_mk;
  usb_power_control #(.SETTLE(SET)) dut_u (.i_clk_sys(clk),
    .i_nrst(nrst), .i_clk_usb(clk_usb), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pw), .i_paddr(pa), .i_pwdata(pwd),
    .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
    .i_bus_activity(act), .i_notify_pending(ntf),
    .i_activity_irq_taken(taken), .o_module_power_on(pon),
    .o_usb_outputs_enable(outs), .o_usb_pins_own(pins),
    .o_analog_enable(ana), .o_xcvr_low_power(lowp),
    .o_clk_usb_gated(gclk), .o_sleep_block(sblk), .o_irq(irq));
  usb_bus_model bus_u (.i_act_req(act_req), .i_notify_req(ntf_req),
    .o_clk_usb(clk_usb), .o_activity(act), .o_notify(ntf));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge gclk) gcnt++;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pw <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 50)
      errors++;
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(negedge clk);
  endtask
  function automatic logic [31:0] ectl(input int busy, input int pend);
    return (m_ctl & 32'h13) | (busy << 3) | (pend << 7);
  endfunction
  task automatic pulse_taken();
    @(posedge clk);
    taken <= 1'b1;
    @(posedge clk);
    taken <= 1'b0;
  endtask
  initial
  begin
    #100000;
    errors++;
    stop_test();
  end
  initial
  begin
    {nrst, psel, pen, pw, taken, act_req, ntf_req} = '0;
    pa = '0;
    pwd = '0;
    {errors, samples_checked, gcnt, m_ctl, m_st, m_mk} = '0;
    void'($urandom(26));
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk("reset", 32'h0, rd);
    end
    apb(1'b1, 12'hFF0, 32'hFFFF_FFFF);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'b0, 12'hFF0, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test reset done");
    m_ctl = 32'h13;
    apb(1'b1, 12'h000, 32'hFFFF_FFFF);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctl on", ectl(1, 0), rd);
    chk("pins", 32'hF, {28'h0, pon, outs, pins, ana});
    chk("lowp", 32'h1, {31'h0, lowp});
    repeat (20) @(posedge clk);
    gcnt = 0;
    repeat (40) @(posedge clk);
    chk("gated", 32'h0, gcnt);
    m_ctl = 32'h11;
    apb(1'b1, 12'h000, 32'h11);
    repeat (20) @(posedge clk);
    gcnt = 0;
    repeat (40) @(posedge clk);
    chk("running", 32'h1, {31'h0, gcnt > 30});
    chk("lowp", 32'h0, {31'h0, lowp});
    $display("test suspend done");
    act_req <= 1'b1;
    repeat (10) @(posedge clk);
    chk("sleep", 32'h1, {31'h0, sblk});
    apb(1'b0, 12'h000, 32'h0);
    chk("pend", ectl(1, 1), rd);
    m_st = 1;
    m_mk = $urandom;
    apb(1'b1, 12'h008, 32'(m_mk));
    m_mk = m_mk & 2;
    apb(1'b1, 12'h008, 32'(m_mk));
    chk("irq masked", 32'h0, {31'h0, irq});
    m_mk = 1;
    apb(1'b1, 12'h008, 32'(m_mk));
    chk("irq", 32'h1, {31'h0, irq});
    act_req <= 1'b0;
    repeat (10) @(posedge clk);
    pulse_taken();
    apb(1'b0, 12'h000, 32'h0);
    chk("unpend", ectl(1, 0), rd);
    apb(1'b1, 12'h004, 32'h1);
    chk("irq clear", 32'h0, {31'h0, irq});
    m_ctl = 32'h01;
    apb(1'b1, 12'h000, 32'h01);
    act_req <= 1'b1;
    repeat (10) @(posedge clk);
    chk("no guard", 32'h0, {31'h0, sblk});
    act_req <= 1'b0;
    repeat (10) @(posedge clk);
    pulse_taken();
    m_ctl = 32'h11;
    apb(1'b1, 12'h000, 32'h11);
    ntf_req <= 1'b1;
    repeat (10) @(posedge clk);
    chk("notify", 32'h1, {31'h0, sblk});
    ntf_req <= 1'b0;
    apb(1'b1, 12'h004, 32'h3);
    $display("test activity done");
    m_ctl = 0;
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk("settling", ectl(1, 0), rd);
    chk("pins off", 32'h0, {28'h0, pon, outs, pins, ana});
    repeat (SET + 10) @(posedge clk);
    apb(1'b0, 12'h000, 32'h0);
    chk("ready", ectl(0, 0), rd);
    apb(1'b0, 12'h004, 32'h0);
    chk("ready irq", 32'h2, rd);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, 12'h008, 32'h3);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b1, 12'h004, 32'h2);
    chk("irq gone", 32'h0, {31'h0, irq});
    $display("test power off done");
    stop_test();
  end
endmodule
